// >>> rtl/crt_video_timing_control.sv
// video timing, sync, blanking and cursor generation with axi4-lite control
// Functional notes
// - horizontal sync with fixed width, position, polarity in character times
// - optional serration pulses on horizontal sync during vertical sync
// - vertical sync with fixed width, position, polarity in scan lines
// - cursor high two character times after address matches cursor register
// - cursor on every scan line of cell or one chosen line
// - cursor forced off during horizontal and vertical blanking
// - advanced mode shifts cursor a line earlier; first row loses first line
// - refresh input high selects first frame rate, low second rate
// - vertical blank starts after last video line, ends in prior row
// - address mode 1 aligns rows; 0 starts rows on previous last line
// - advanced addressing also moves recirculate and cursor one line earlier
// - in address mode 0, half-row input low repeats each even row's addressing on the following odd row
// - half-row second row suppresses shift load and cursor outputs
// - test clock input is ignored in normal operation
// - reset low halts, enters vertical blank, clears top and cursor registers
// - after reset timing resumes in vertical blank then addresses from zero
// - dots per character between 4 and 16; the 3-bit dot divider here counts only up to 8
// - scan lines per row between 2 and 16
// - single-line cursor needs blank end line 1, 0 or cursor line
`timescale 1ns/1ps
`include "crt_timing_regs.svh"
module crt_video_timing_control (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic refreshSel,
  input wire logic addrMode,
  input wire logic fullRow,
  input wire logic testClk,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [11:0] ramAddr,
  output logic [3:0] lineCount,
  output crt_timing_pkg::video_out_type vidOut
);
  // pin synchronisers
  logic [1:0] refSync_reg, modeSync_reg, fullSync_reg;
  logic refreshS, modeS, fullS;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      refSync_reg <= 2'h0;
      modeSync_reg <= 2'h0;
      fullSync_reg <= 2'h0;
    end else if (ce) begin
      refSync_reg <= {refSync_reg[0], refreshSel};
      modeSync_reg <= {modeSync_reg[0], addrMode};
      fullSync_reg <= {fullSync_reg[0], fullRow};
    end
  end
  assign refreshS = refSync_reg[1];
  assign modeS = modeSync_reg[1];
  assign fullS = fullSync_reg[1];
  // test clock has no internal load at all
  logic unusedTest;
  assign unusedTest = testClk;

  // registers
  logic [31:0] ctrl_reg;
  logic [11:0] cursor_reg, top_reg;
  logic serrEn, oneLine;
  logic [3:0] curLine;
  assign serrEn = ctrl_reg[`CRT_CTRL_SERR_BIT];
  assign oneLine = ctrl_reg[`CRT_CTRL_ONELINE_BIT];
  assign curLine = ctrl_reg[`CRT_CTRL_CURLINE_LSB +: 4];

  // axi4-lite write: address and data taken in either order
  logic awHave_reg, wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  logic [31:0] wMerged;
  always_comb begin
    wMerged = 32'h00000000;
    if (awAddr_reg == `CRT_OFF_CTRL) begin
      wMerged = merge(ctrl_reg, wData_reg, wStrb_reg);
    end else if (awAddr_reg == `CRT_OFF_CURSOR) begin
      wMerged = merge({20'h00000, cursor_reg}, wData_reg, wStrb_reg);
    end else if (awAddr_reg == `CRT_OFF_TOP) begin
      wMerged = merge({20'h00000, top_reg}, wData_reg, wStrb_reg);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_reg <= `CRT_CTRL_RESET;
      cursor_reg <= 12'h000;
      top_reg <= 12'h000;
    end else if (ce && doWrite) begin
      if (awAddr_reg == `CRT_OFF_CTRL) begin
        ctrl_reg <= wMerged;
      end else if (awAddr_reg == `CRT_OFF_CURSOR) begin
        cursor_reg <= wMerged[11:0];
      end else if (awAddr_reg == `CRT_OFF_TOP) begin
        top_reg <= wMerged[11:0];
      end
    end
  end

  // timing state
  crt_timing_pkg::phase_type phase_reg;
  logic [2:0] dotDiv_reg;
  logic [7:0] charCnt_reg;
  logic [3:0] line_reg;
  logic [4:0] row_reg;
  logic [9:0] frameLine_reg;
  logic [11:0] addr_reg, rowStart_reg;
  logic charTick, lineTick, lastLine, advLine, pairSecond;
  logic [9:0] linesPerFrame;
  // dot clock divided to character rate; dots/char fixed at a legal 4..16
  assign charTick = (dotDiv_reg == 3'(`CRT_DOTS_PER_CHAR - 4'h1));
  assign lineTick = charTick && (charCnt_reg == `CRT_CHARS_TOTAL - 8'h01);
  // lines per row fixed at a legal 2..16
  assign lastLine = (line_reg == `CRT_LINES_PER_ROW - 4'h1);
  assign linesPerFrame = refreshS ? `CRT_LINES_F1 : `CRT_LINES_F0;
  // advanced mode: new row begins on previous row's last line
  assign advLine = modeS ? (line_reg == 4'h0) : lastLine;
  assign pairSecond = !fullS && row_reg[0];
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dotDiv_reg <= 3'h0;
      charCnt_reg <= 8'h00;
    end else if (ce) begin
      dotDiv_reg <= charTick ? 3'h0 : dotDiv_reg + 3'h1;
      if (charTick) begin
        charCnt_reg <= lineTick ? 8'h00 : charCnt_reg + 8'h01;
      end
    end
  end
  // reset parks at start of vertical blank; release resumes there
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      phase_reg <= crt_timing_pkg::PH_VBLANK;
      frameLine_reg <= 10'(`CRT_ROWS_VIDEO) * 10'(`CRT_LINES_PER_ROW);
      line_reg <= 4'h0;
      row_reg <= 5'h00;
    end else if (ce && lineTick) begin
      if (frameLine_reg == linesPerFrame - 10'h001) begin
        frameLine_reg <= 10'h000;
        line_reg <= 4'h0;
        row_reg <= 5'h00;
        phase_reg <= crt_timing_pkg::PH_VIDEO;
      end else begin
        frameLine_reg <= frameLine_reg + 10'h001;
        line_reg <= lastLine ? 4'h0 : line_reg + 4'h1;
        if (lastLine) begin
          row_reg <= row_reg + 5'h01;
          if (row_reg == `CRT_ROWS_VIDEO - 5'h01) begin
            phase_reg <= crt_timing_pkg::PH_VBLANK;
          end
        end
      end
    end
  end
  // addressing; in address mode 0 half-row keeps the row start for the second row of a pair
  logic hVideo, inVideo;
  assign hVideo = charCnt_reg < `CRT_CHARS_VIDEO;
  assign inVideo = phase_reg == crt_timing_pkg::PH_VIDEO;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      addr_reg <= 12'h000;
      rowStart_reg <= 12'h000;
    end else if (ce && charTick) begin
      if (lineTick) begin
        if (frameLine_reg == linesPerFrame - 10'h001) begin
          addr_reg <= top_reg; // first row starts from top of page
          rowStart_reg <= top_reg;
        end else if (inVideo && advLine && !(!fullS && !row_reg[0] && lastLine)) begin
          addr_reg <= addr_reg; // next row continues sequentially
          rowStart_reg <= addr_reg;
        end else if (inVideo) begin
          addr_reg <= rowStart_reg;
        end
      end else if (hVideo) begin
        addr_reg <= addr_reg + 12'h001;
      end
    end
  end
  assign ramAddr = addr_reg;
  assign lineCount = line_reg;

  // cursor compare and two character delay
  logic curMatch, curDelayed, curLineOk, vbNow;
  logic [3:0] effLine;
  assign curMatch = (addr_reg == cursor_reg) && hVideo;
  crt_cursor_delay curDelay (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .charTick(charTick),
    .matchIn(curMatch),
    .matchOut(curDelayed)
  );
  // advanced mode moves cursor one line earlier
  assign effLine = (!modeS) ? (lastLine ? 4'h0 : line_reg + 4'h1) : line_reg;
  // single line cursor; blank end line kept at 0 for compatibility
  assign curLineOk = oneLine ? (effLine == curLine) : 1'b1;
  // vertical blank also covers the advanced first line of row 0
  assign vbNow = !inVideo || (!modeS && (frameLine_reg == linesPerFrame - 10'h001)
                 && (line_reg != `CRT_VB_END_LINE));

  logic vsAct, hsAct, serr;
  logic [9:0] vsOff;
  logic [7:0] hsOff;
  assign vsOff = frameLine_reg - `CRT_VS_START;
  assign vsAct = vsOff < `CRT_VS_WIDTH;
  assign hsOff = charCnt_reg - `CRT_HS_START;
  assign hsAct = hsOff < `CRT_HS_WIDTH;
  // serrations: short pulse at line start and mid line while vertical sync
  assign serr = (charCnt_reg < `CRT_SERR_WIDTH) ||
                ((charCnt_reg - (`CRT_CHARS_TOTAL >> 1)) < `CRT_SERR_WIDTH);
  // outputs registered on character ticks only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      vidOut <= '{hSync: !`CRT_HS_POL, vSync: !`CRT_VS_POL, vBlank: `CRT_VB_POL,
                  cursorEn: 1'b0, loadShift: 1'b0, recirc: 1'b0};
    end else if (ce && charTick) begin
      vidOut.hSync <= ((serrEn && vsAct) ? serr : hsAct) ~^ `CRT_HS_POL;
      vidOut.vSync <= vsAct ~^ `CRT_VS_POL;
      vidOut.vBlank <= vbNow ~^ `CRT_VB_POL;
      // blanking and half-row second row kill the cursor
      vidOut.cursorEn <= curDelayed && curLineOk && hVideo && !vbNow && !pairSecond;
      vidOut.loadShift <= hVideo && !vbNow && !pairSecond;
      vidOut.recirc <= !advLine;
    end
  end

  // status and read path
  logic [31:0] rdVal;
  always_comb begin
    rdVal = 32'h00000000;
    if (s_axi_araddr == `CRT_OFF_CTRL) begin
      rdVal = ctrl_reg;
    end else if (s_axi_araddr == `CRT_OFF_CURSOR) begin
      rdVal = {20'h00000, cursor_reg};
    end else if (s_axi_araddr == `CRT_OFF_TOP) begin
      rdVal = {20'h00000, top_reg};
    end else if (s_axi_araddr == `CRT_OFF_STATUS) begin
      rdVal = {16'h0000, row_reg, line_reg, vidOut.vBlank, vidOut.vSync,
               vidOut.hSync, vidOut.cursorEn, fullS, modeS, refreshS};
    end else if (s_axi_araddr == `CRT_OFF_ADDR) begin
      rdVal = {20'h00000, addr_reg};
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> rtl/crt_timing_regs.svh
// register offsets, reset values and timing counts for the crt timing block
`ifndef CRT_TIMING_REGS_SVH
`define CRT_TIMING_REGS_SVH
`define CRT_OFF_CTRL 8'h00
`define CRT_OFF_CURSOR 8'h04
`define CRT_OFF_TOP 8'h08
`define CRT_OFF_STATUS 8'h0c
`define CRT_OFF_ADDR 8'h10
`define CRT_CTRL_SERR_BIT 0
`define CRT_CTRL_ONELINE_BIT 1
`define CRT_CTRL_CURLINE_LSB 4
`define CRT_CTRL_RESET 32'h00000000
`define CRT_DOTS_PER_CHAR 4'h8
`define CRT_LINES_PER_ROW 4'ha
`define CRT_CHARS_VIDEO 8'h50
`define CRT_CHARS_TOTAL 8'h64
`define CRT_HS_START 8'h54
`define CRT_HS_WIDTH 8'h08
`define CRT_HS_POL 1'b1
`define CRT_SERR_WIDTH 8'h04
`define CRT_ROWS_VIDEO 5'h18
`define CRT_LINES_F1 10'h106
`define CRT_LINES_F0 10'h138
`define CRT_VS_START 10'h0f4
`define CRT_VS_WIDTH 10'h003
`define CRT_VB_POL 1'b1
`define CRT_VS_POL 1'b1
`define CRT_VB_END_LINE 4'h0
`define CRT_CUR_DELAY 2
`define CRT_RESET_MIN_NS 250
`define CRT_CLK_NS 25
`define CRT_RESET_MIN_CYC ((`CRT_RESET_MIN_NS + `CRT_CLK_NS - 1) / `CRT_CLK_NS)
`endif

// >>> rtl/crt_timing_pkg.sv
// types shared by the crt timing block
package crt_timing_pkg;
  typedef enum logic [1:0] {
    PH_VBLANK = 2'b00,
    PH_VIDEO = 2'b01
  } phase_type;
  typedef struct packed {
    logic hSync;
    logic vSync;
    logic vBlank;
    logic cursorEn;
    logic loadShift;
    logic recirc;
  } video_out_type;
endpackage

// >>> rtl/crt_cursor_delay.sv
// first stage of the two character-time cursor delay; the output register is the second
`timescale 1ns/1ps
module crt_cursor_delay (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic charTick,
  input wire logic matchIn,
  output logic matchOut
);
  // one stage only: a second one here plus the output register would make three
  logic pipe_reg;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pipe_reg <= 1'b0;
    end else if (ce && charTick) begin
      pipe_reg <= matchIn;
    end
  end
  assign matchOut = pipe_reg;
endmodule

// >>> verification/crt_timing_checker_assertions.sv
// assertion checker watching the crt timing block ports
`timescale 1ns/1ps
module crt_timing_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [11:0] ramAddr,
  input wire crt_timing_pkg::video_out_type vidOut
);
  logic [11:0] hsCnt;
  logic [11:0] vsCnt;
  // pulse lengths in clocks, restarted while the pulse is low
  always_ff @(posedge ref_clk) begin
    if (!rstn || !vidOut.hSync) begin
      hsCnt <= 12'h000;
    end else begin
      hsCnt <= hsCnt + 12'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn || !vidOut.vSync) begin
      vsCnt <= 12'h000;
    end else begin
      vsCnt <= vsCnt + 12'h001;
    end
  end
  a_reset_state: assert property (@(posedge ref_clk) !rstn |=>
    vidOut.vBlank && !vidOut.hSync && !vidOut.vSync && !vidOut.cursorEn && ramAddr == 12'h000)
    else $error("outputs not at blank start during reset");
  a_resume_blank: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(rstn) |-> (vidOut.vBlank && !vidOut.cursorEn) [*8])
    else $error("timing did not resume in vertical blank");
  a_hsync_width: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(vidOut.hSync) && !vidOut.vSync |-> hsCnt == 12'h040)
    else $error("horizontal sync width wrong");
  a_vsync_width: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(vidOut.vSync) |-> vsCnt == 12'h960)
    else $error("vertical sync width wrong");
  a_vsync_blanked: assert property (@(posedge ref_clk) disable iff (!rstn)
    vidOut.vSync |-> vidOut.vBlank)
    else $error("vertical sync outside blanking");
  a_cursor_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    vidOut.cursorEn |-> !vidOut.vBlank && !vidOut.hSync)
    else $error("cursor during blanking");
  a_load_blanked: assert property (@(posedge ref_clk) disable iff (!rstn)
    vidOut.loadShift |-> !vidOut.vBlank && !vidOut.hSync)
    else $error("shift load during blanking");
  a_cursor_char: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(vidOut.cursorEn) |-> vidOut.cursorEn [*8])
    else $error("cursor shorter than a character");
  a_read_answer: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_okay: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
endmodule
bind crt_video_timing_control crt_timing_checker chk_i (.*);

// >>> verification/crt_monitor_model.sv
// monitor model: counts scan lines from vertical sync start to end of blanking
`timescale 1ns/1ps
module crt_monitor_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire crt_timing_pkg::video_out_type vidOut,
  output logic [9:0] linesSeen,
  output logic measured
);
  crt_timing_pkg::video_out_type prev;
  logic counting;
  // a monitor locks to leading sync edges only, so trailing edges are ignored
  always_ff @(posedge ref_clk) begin
    prev <= vidOut;
    if (!rstn) begin
      counting <= 1'b0;
      measured <= 1'b0;
      linesSeen <= 10'h000;
    end else if (vidOut.vSync && !prev.vSync) begin
      counting <= 1'b1;
      measured <= 1'b0;
      linesSeen <= 10'h000;
    end else if (counting) begin
      if (vidOut.hSync && !prev.hSync) begin
        linesSeen <= linesSeen + 10'h001;
      end
      if (prev.vBlank && !vidOut.vBlank) begin
        counting <= 1'b0;
        measured <= 1'b1;
      end
    end
  end
endmodule

// >>> verification/tb_top.sv
// self-checking bench: registers, frame rates and cursor timing
`timescale 1ns/1ps
`include "crt_timing_regs.svh"
module tb_top;
  logic ref_clk, rstn, ce, refreshSel, addrMode, fullRow, testClk, measured;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, lineCount;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] ramAddr;
  logic [9:0] linesSeen, firstLines;
  crt_timing_pkg::video_out_type vidOut;
  int fails, samplesChecked;
  crt_video_timing_control uut (.*);
  crt_monitor_model monitor (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) testClk <= ~testClk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic wait_frame();
    while (measured !== 1'b1) @(posedge ref_clk);
  endtask
  task automatic final_report();
    if (fails == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one blanking interval at each of the two rates dominates the run time
  initial begin
    #(90000 * 25);
    fails++;
    final_report();
  end
  initial begin
    {rstn, ce, addrMode, fullRow, testClk, refreshSel} = 6'h1d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    fails = 0;
    samplesChecked = 0;
    do_reset();
    axi_read(`CRT_OFF_CTRL, rd);
    chk(rd, `CRT_CTRL_RESET, "ctrl reset value");
    axi_read(`CRT_OFF_CURSOR, rd);
    chk(rd, 32'h00000000, "cursor after reset");
    axi_write(`CRT_OFF_CURSOR, 32'h00000005);
    axi_read(`CRT_OFF_CURSOR, rd);
    chk(rd, 32'h00000005, "cursor readback");
    axi_read(8'h40, rd);
    chk(rd, 32'h00000000, "unmapped read");
    axi_read(`CRT_OFF_STATUS, rd);
    chk({31'h0, rd[0]}, 32'h00000001, "status refresh bit");
    wait_frame();
    firstLines = linesSeen;
    // cursor must trail the matching address by two characters, not one
    while (ramAddr !== 12'h004) @(posedge ref_clk);
    while (ramAddr !== 12'h005) @(posedge ref_clk);
    repeat (11) @(posedge ref_clk);
    #1;
    chk({31'h0, vidOut.cursorEn}, 32'h00000000, "cursor one char early");
    repeat (8) @(posedge ref_clk);
    #1;
    chk({31'h0, vidOut.cursorEn}, 32'h00000001, "cursor two chars late");
    chk({31'h0, vidOut.loadShift}, 32'h00000001, "shift load in video");
    chk({28'h0, lineCount}, 32'h00000000, "first scan line of row");
    @(posedge ref_clk);
    refreshSel <= 1'b0;
    do_reset();
    axi_read(`CRT_OFF_CURSOR, rd);
    chk(rd, 32'h00000000, "cursor cleared by reset");
    wait_frame();
    chk({22'h0, linesSeen - firstLines}, 32'h00000032, "lines added at second rate");
    final_report();
  end
endmodule
